// *** verilog/external_data_space_map_params.svh ***
`ifndef EXTERNAL_DATA_SPACE_MAP_PARAMS_SVH
`define EXTERNAL_DATA_SPACE_MAP_PARAMS_SVH
// Special register addresses
`define ADDR_PAGE 8'hAA
`define ADDR_CFG 8'h85
`define ADDR_DPH 8'h83
`define ADDR_DPL 8'h82
// Reset values
`define PAGE_RST 8'h00
`define CFG_RST 8'h03
`define DATA_POINTER_RST 16'h0000
// Configuration fields
`define CFG_FAE 6
`define CFG_MUXOFF 4
`define CFG_MODE_HI 3
`define CFG_MODE_LO 2
`define CFG_MASK 8'h5F
// Address map
`define FIFO_LO 16'h0400
`define FIFO_HI 16'h07FF
`define ONCHIP_TOP 16'h1000
`define FIFO_AW 10
// Access timing in system clocks
`define FIFO_MIN_CYC 4'h3
`define EXT_CYC 4'h4
`define EXT_STB_ON 4'h3
`define EXT_STB_OFF 4'h1
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`endif

// *** verilog/external_data_space_map_pkg.sv ***
`default_nettype none
package external_data_space_map_pkg;
  typedef enum logic [1:0] {
    MODE_ONCHIP = 2'b00,
    MODE_SPLIT_NOBANK = 2'b01,
    MODE_SPLIT_BANK = 2'b10,
    MODE_OFFCHIP = 2'b11
  } mem_mode_t;
  typedef enum logic [1:0] {
    TGT_EXTERNAL_DATA_SPACE = 2'b00,
    TGT_FIFO = 2'b01,
    TGT_EXT = 2'b10
  } target_t;
  typedef struct packed {
    logic we;
    logic use_data_pointer;
    logic sel_b;
    logic [7:0] wdata;
  } move_cmd_t;
  typedef struct packed {
    logic own;
    logic [15:0] addr;
    logic addr_hi_oe;
    logic [7:0] data;
    logic data_oe;
    logic wr_n;
    logic rd_n;
    logic ale;
  } pins_t;
endpackage
`default_nettype wire

// *** verilog/external_data_space_access_address_map.sv ***
`default_nettype none
`include "external_data_space_map_params.svh"
module external_data_space_access_address_map (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Special register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // External move request from the core
  input wire logic mv_req_i,
  input wire external_data_space_map_pkg::move_cmd_t mv_cmd_i,
  input wire logic [7:0] ptr_a_i,
  input wire logic [7:0] ptr_b_i,
  output logic mv_done_o,
  output logic [7:0] mv_rdata_o,
  // On-chip data memory
  output logic xr_req_o,
  output logic xr_we_o,
  output logic [15:0] xr_addr_o,
  output logic [7:0] xr_wdata_o,
  input wire logic [7:0] xr_rdata_i,
  // FIFO bridge into the USB clock domain
  output logic ff_req_o,
  output logic ff_we_o,
  output logic [`FIFO_AW-1:0] ff_addr_o,
  output logic [7:0] ff_wdata_o,
  input wire logic ff_ack_i,
  input wire logic [7:0] ff_rdata_i,
  // Off-chip memory pins
  output var external_data_space_map_pkg::pins_t pins_o,
  input wire logic [7:0] pin_data_i
);
  import external_data_space_map_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXTERNAL_DATA_SPACE = 2'b01,
    S_FIFO = 2'b10,
    S_EXT = 2'b11
  } state_t;

  state_t state_q;
  logic [7:0] page_q;
  logic [7:0] cfg_q;
  logic [15:0] data_pointer_q;
  logic [3:0] cnt_q;
  logic [15:0] addr;
  target_t tgt;
  mem_mode_t mode;
  logic fae;

  // Window test used by routing and checks
  function automatic logic in_window(input logic [15:0] a);
    in_window = (a >= `FIFO_LO) && (a <= `FIFO_HI);
  endfunction

  // Routing by memory mode and FIFO overlay
  function automatic target_t route(input logic [15:0] a, input mem_mode_t m,
                                    input logic f);
    if (f && in_window(a)) begin
      route = TGT_FIFO;
    end else begin
      unique case (m)
        MODE_ONCHIP: route = TGT_EXTERNAL_DATA_SPACE;
        MODE_SPLIT_NOBANK, MODE_SPLIT_BANK:
          route = (a < `ONCHIP_TOP) ? TGT_EXTERNAL_DATA_SPACE : TGT_EXT;
        MODE_OFFCHIP: route = TGT_EXT;
      endcase
    end
  endfunction

  assign fae = cfg_q[`CFG_FAE];
  assign mode = mem_mode_t'(cfg_q[`CFG_MODE_HI:`CFG_MODE_LO]);

  // Effective address of the requested move
  always_comb begin
    if (mv_cmd_i.use_data_pointer) begin
      addr = data_pointer_q;
    end else begin
      addr = {page_q, mv_cmd_i.sel_b ? ptr_b_i : ptr_a_i};
    end
    tgt = route(addr, mode, fae);
  end

  // Special register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_q <= `PAGE_RST;
      cfg_q <= `CFG_RST;
      data_pointer_q <= `DATA_POINTER_RST;
    end else if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        `ADDR_PAGE: page_q <= sfr_wdata_i;
        `ADDR_CFG: cfg_q <= sfr_wdata_i & `CFG_MASK;
        `ADDR_DPH: data_pointer_q[15:8] <= sfr_wdata_i;
        `ADDR_DPL: data_pointer_q[7:0] <= sfr_wdata_i;
        default: ;
      endcase
    end
  end

  // Registered read-back, unused bits read zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      unique case (sfr_addr_i)
        `ADDR_PAGE: sfr_rdata_o <= page_q;
        `ADDR_CFG: sfr_rdata_o <= cfg_q;
        `ADDR_DPH: sfr_rdata_o <= data_pointer_q[15:8];
        `ADDR_DPL: sfr_rdata_o <= data_pointer_q[7:0];
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // Access sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
      cnt_q <= `CNT_ZERO;
      mv_done_o <= 1'b0;
      mv_rdata_o <= 8'h00;
      xr_req_o <= 1'b0;
      xr_we_o <= 1'b0;
      xr_addr_o <= 16'h0000;
      xr_wdata_o <= 8'h00;
      ff_req_o <= 1'b0;
      ff_we_o <= 1'b0;
      ff_addr_o <= '0;
      ff_wdata_o <= 8'h00;
    end else begin
      mv_done_o <= 1'b0;
      xr_req_o <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (mv_req_i) begin
            unique case (tgt)
              TGT_EXTERNAL_DATA_SPACE: begin
                state_q <= S_EXTERNAL_DATA_SPACE;
                xr_req_o <= 1'b1;
                xr_we_o <= mv_cmd_i.we;
                xr_addr_o <= addr;
                xr_wdata_o <= mv_cmd_i.wdata;
              end
              TGT_FIFO: begin
                // Held until the USB side answers
                state_q <= S_FIFO;
                cnt_q <= `FIFO_MIN_CYC;
                ff_req_o <= 1'b1;
                ff_we_o <= mv_cmd_i.we;
                ff_addr_o <= addr[`FIFO_AW-1:0];
                ff_wdata_o <= mv_cmd_i.wdata;
              end
              TGT_EXT: begin
                state_q <= S_EXT;
                cnt_q <= `EXT_CYC;
              end
              default: state_q <= S_IDLE;
            endcase
          end
        end
        S_EXTERNAL_DATA_SPACE: begin
          mv_rdata_o <= xr_rdata_i;
          mv_done_o <= 1'b1;
          state_q <= S_IDLE;
        end
        S_FIFO: begin
          if (cnt_q != `CNT_ZERO) begin
            cnt_q <= cnt_q - `CNT_ONE;
          end
          if (ff_ack_i) begin
            ff_req_o <= 1'b0;
            mv_rdata_o <= ff_rdata_i;
          end
          if (!ff_req_o && cnt_q == `CNT_ZERO) begin
            mv_done_o <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_EXT: begin
          cnt_q <= cnt_q - `CNT_ONE;
          if (cnt_q == `EXT_STB_OFF) begin
            mv_rdata_o <= pin_data_i;
          end
          if (cnt_q == `CNT_ONE) begin
            mv_done_o <= 1'b1;
            state_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Off-chip pin control; output type is left to the port logic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_o.own <= 1'b0;
      pins_o.addr <= 16'h0000;
      pins_o.addr_hi_oe <= 1'b0;
      pins_o.data <= 8'h00;
      pins_o.data_oe <= 1'b0;
      pins_o.wr_n <= 1'b1;
      pins_o.rd_n <= 1'b1;
      pins_o.ale <= 1'b0;
    end else if (state_q == S_IDLE && mv_req_i && tgt == TGT_EXT) begin
      pins_o.own <= 1'b1;
      pins_o.addr <= addr;
      // Without bank select, page-form moves leave the high byte to the port latch
      pins_o.addr_hi_oe <= !(mode == MODE_SPLIT_NOBANK && !mv_cmd_i.use_data_pointer);
      pins_o.data <= mv_cmd_i.wdata;
      pins_o.data_oe <= mv_cmd_i.we;
      pins_o.ale <= !cfg_q[`CFG_MUXOFF];
    end else if (state_q == S_EXT) begin
      pins_o.ale <= 1'b0;
      if (cnt_q == `EXT_STB_ON) begin
        pins_o.wr_n <= !pins_o.data_oe;
        pins_o.rd_n <= pins_o.data_oe;
      end
      if (cnt_q == `EXT_STB_OFF) begin
        pins_o.wr_n <= 1'b1;
        pins_o.rd_n <= 1'b1;
      end
      if (cnt_q == `CNT_ONE) begin
        pins_o.own <= 1'b0;
        pins_o.addr_hi_oe <= 1'b0;
        pins_o.data_oe <= 1'b0;
      end
    end
  end

  // Checks
  a_data_pointer_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == S_IDLE && mv_req_i && mv_cmd_i.use_data_pointer && tgt == TGT_EXTERNAL_DATA_SPACE
    |=> xr_req_o && xr_addr_o == $past(data_pointer_q))
    else $error("pointer form address wrong");
  a_dph_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sfr_wr_i && sfr_addr_i == `ADDR_DPH
    |=> data_pointer_q[15:8] == $past(sfr_wdata_i) && $stable(data_pointer_q[7:0]))
    else $error("high pointer byte write wrong");
  a_page_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == S_IDLE && mv_req_i && !mv_cmd_i.use_data_pointer && tgt == TGT_EXTERNAL_DATA_SPACE
    |=> xr_addr_o[15:8] == $past(page_q))
    else $error("indirect high byte wrong");
  a_fifo_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(ff_req_o) |-> fae && in_window({6'h01, ff_addr_o}))
    else $error("fifo access outside window");
  a_window_hidden: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    xr_req_o |-> !(fae && in_window(xr_addr_o)))
    else $error("window reached plain memory");
  a_fifo_slow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(ff_req_o) |-> !mv_done_o [*3])
    else $error("fifo move too fast");
  a_own_ext: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pins_o.own |-> state_q == S_EXT)
    else $error("pins owned outside off-chip move");
  a_own_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mv_done_o && $past(state_q == S_EXT) |-> !pins_o.own && pins_o.wr_n && pins_o.rd_n)
    else $error("pins not released");
  a_read_undriven: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !pins_o.rd_n |-> !pins_o.data_oe)
    else $error("data driven during read");
  a_ale_mux: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pins_o.ale |-> !cfg_q[`CFG_MUXOFF] && pins_o.own ##1 !pins_o.ale)
    else $error("address latch strobe wrong");
  a_offchip_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    xr_req_o |-> mode != MODE_OFFCHIP)
    else $error("on-chip access in off-chip mode");
  a_window_plain: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == S_IDLE && mv_req_i && !fae && mode == MODE_ONCHIP && in_window(addr)
    |=> xr_req_o)
    else $error("window not plain memory");
  c_external_data_space: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == S_EXTERNAL_DATA_SPACE ##1 mv_done_o);
  c_fifo: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_q == S_FIFO && ff_ack_i);
  c_ext_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    !pins_o.rd_n ##[1:4] mv_done_o);
endmodule
`default_nettype wire

// *** verification/external_data_space_offchip_mem.sv ***
`default_nettype none
module external_data_space_offchip_mem (
  // Clock
  input wire logic clk_i,
  // Memory bus pins
  input wire external_data_space_map_pkg::pins_t pins_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import external_data_space_map_pkg::*;
  logic [7:0] mem_q [256];
  logic [7:0] last_q = 8'h00;
  logic wr_pin;
  logic rd_pin;
  // Port latches park the strobes high whenever the interface lets go
  assign wr_pin = pins_i.own ? pins_i.wr_n : 1'b1;
  assign rd_pin = pins_i.own ? pins_i.rd_n : 1'b1;
  // Store while write strobe is low, remember last read byte
  always_ff @(posedge clk_i) begin
    if (!wr_pin) mem_q[pins_i.addr[7:0]] <= pins_i.data;
    if (!rd_pin) last_q <= mem_q[pins_i.addr[7:0]];
  end
  // Drive only under read strobe, else an inverted stale value
  assign data_o = !rd_pin ? mem_q[pins_i.addr[7:0]] : ~last_q;
endmodule
`default_nettype wire

// *** verification/external_data_space_access_address_map_tb_top.sv ***
`default_nettype none
module external_data_space_access_address_map_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import external_data_space_map_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, ptr_a_i, ptr_b_i, mv_rdata_o;
  logic sfr_wr_i, mv_req_i, mv_done_o, xr_req_o, xr_we_o, ff_req_o, ff_we_o;
  logic [7:0] xr_wdata_o, xr_rdata_i, ff_wdata_o, ff_rdata_i, pin_data_i, rdv;
  logic [15:0] xr_addr_o, xa, pa;
  logic [9:0] ff_addr_o, fa;
  logic ff_ack_i = 1'b0;
  logic [2:0] bc = 3'd0;
  logic xs, fs, os, wl, rl, ob, ext, al, ho;
  logic [8:0] xw, fw;
  logic [7:0] n;
  move_cmd_t mv_cmd_i;
  pins_t pins_o;
  int fail_count = 0;
  int check_count = 0;
  external_data_space_access_address_map uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .mv_req_i(mv_req_i), .mv_cmd_i(mv_cmd_i), .ptr_a_i(ptr_a_i), .ptr_b_i(ptr_b_i),
    .mv_done_o(mv_done_o), .mv_rdata_o(mv_rdata_o), .xr_req_o(xr_req_o), .xr_we_o(xr_we_o),
    .xr_addr_o(xr_addr_o), .xr_wdata_o(xr_wdata_o), .xr_rdata_i(xr_rdata_i),
    .ff_req_o(ff_req_o), .ff_we_o(ff_we_o), .ff_addr_o(ff_addr_o), .ff_wdata_o(ff_wdata_o),
    .ff_ack_i(ff_ack_i), .ff_rdata_i(ff_rdata_i), .pins_o(pins_o), .pin_data_i(pin_data_i));
  external_data_space_offchip_mem mem (.clk_i(clk_i), .pins_i(pins_o), .data_o(pin_data_i));
  // Clock
  always #2 clk_i = ~clk_i;
  // On-chip memory answers with a pattern of the address
  assign xr_rdata_i = xr_addr_o[7:0] ^ 8'h5A;
  assign ff_rdata_i = ff_addr_o[7:0];
  // FIFO bridge acknowledges a held request after a few cycles
  always @(posedge clk_i) begin
    ff_ack_i <= 1'b0;
    bc <= (ff_req_o && !ff_ack_i) ? bc + 3'd1 : 3'd0;
    if (bc == 3'd3) ff_ack_i <= 1'b1;
  end
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #1 sfr_wr_i = 1'b0;
    // Let one edge pass with the strobe low before the next access
    @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e);
    sfr_addr_i = a;
    @(posedge clk_i);
    #1 chk(sfr_rdata_o, e);
  endtask
  // One move, watching all three targets until done
  task automatic mv(input logic we, dp, sb, input logic [7:0] wd);
    int i;
    logic fin;
    {n, xs, fs, os, wl, rl, ob, al, ho, xw, fw} = '0;
    fin = 1'b0;
    mv_cmd_i = '{we, dp, sb, wd};
    mv_req_i = 1'b1;
    @(posedge clk_i);
    #1 mv_req_i = 1'b0;
    // Sample before each wait so one-cycle pulses after the request are seen
    for (i = 0; i < 40 && !fin; i++) begin
      if (xr_req_o) {xs, xa, xw} = {1'b1, xr_addr_o, xr_we_o, xr_wdata_o};
      if (ff_req_o) {fs, fa, fw} = {1'b1, ff_addr_o, ff_we_o, ff_wdata_o};
      if (pins_o.own) {os, pa, ho} = {1'b1, pins_o.addr, pins_o.addr_hi_oe};
      if (!pins_o.wr_n) wl = 1'b1;
      if (!pins_o.rd_n) rl = 1'b1;
      if (pins_o.ale) al = 1'b1;
      if (!we && pins_o.data_oe) ob = 1'b1;
      fin = (mv_done_o === 1'b1);
      if (!fin) begin
        @(posedge clk_i);
        #1 n++;
      end
    end
    chk(mv_done_o, 1'b1);
    rdv = mv_rdata_o;
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000 fail_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    {sfr_addr_i, sfr_wr_i, sfr_wdata_i, mv_req_i, mv_cmd_i} = '0;
    ptr_a_i = 8'h77;
    ptr_b_i = 8'h34;
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk(pins_o.own, 1'b0);
    rd(8'hAA, 8'h00);
    rd(8'h85, 8'h03);
    rd(8'h83, 8'h00);
    rd(8'h90, 8'h00);
    wr(8'h83, 8'h01);
    wr(8'h82, 8'h23);
    rd(8'h83, 8'h01);
    rd(8'h82, 8'h23);
    wr(8'h85, 8'hFF);
    rd(8'h85, 8'h5F);
    wr(8'h85, 8'h03);
    mv(1'b0, 1'b1, 1'b0, 8'h00);
    chk(xa, 16'h0123);
    chk(rdv, 8'h23 ^ 8'h5A);
    chk(n, 8'd1);
    wr(8'hAA, 8'h12);
    mv(1'b0, 1'b0, 1'b1, 8'h00);
    chk(xa, 16'h1234);
    mv(1'b0, 1'b0, 1'b0, 8'h00);
    chk(xa, 16'h1277);
    wr(8'h83, 8'h04);
    wr(8'h82, 8'h56);
    wr(8'h85, 8'h43);
    mv(1'b0, 1'b1, 1'b0, 8'h00);
    chk({fs, xs}, 2'b10);
    chk(fa, 10'h056);
    chk(rdv, 8'h56);
    chk(n > 8'd3, 1'b1);
    mv(1'b1, 1'b1, 1'b0, 8'h3C);
    chk({fs, fw, fa}, {1'b1, 9'h13C, 10'h056});
    wr(8'h85, 8'h03);
    mv(1'b0, 1'b1, 1'b0, 8'h00);
    chk({fs, xs, xa}, {2'b01, 16'h0456});
    wr(8'h83, 8'h23);
    wr(8'h82, 8'h45);
    for (int m = 0; m < 4; m++) begin
      wr(8'h85, {4'h1, m[1:0], 2'b11});
      ext = (m != 0);
      mv(1'b1, 1'b1, 1'b0, 8'hA0 + 8'(m));
      chk({os, xs}, {ext, !ext});
      if (!ext) chk(xw, {1'b1, 8'hA0});
      if (ext) chk({pa, wl, rl}, {16'h2345, 2'b10});
      if (ext) chk({ho, al}, 2'b10);
      mv(1'b0, 1'b1, 1'b0, 8'h00);
      chk(rdv, ext ? 8'hA0 + 8'(m) : 8'h45 ^ 8'h5A);
      chk({ob, wl}, 2'b00);
      chk(pins_o.own, 1'b0);
    end
    // Multiplexed off-chip read raises the address latch strobe
    wr(8'h85, 8'h0F);
    mv(1'b0, 1'b1, 1'b0, 8'h00);
    chk({os, al, rl, rdv}, {3'b111, 8'hA3});
    // Split mode without bank select leaves the high byte to the latch
    wr(8'h85, 8'h17);
    mv(1'b0, 1'b0, 1'b0, 8'h00);
    chk({os, ho, pa}, {2'b10, 16'h1277});
    finish_test();
  end
endmodule
`default_nettype wire
